// ---- wake_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  wake-up timer, receive windowing, pin routing and antenna select block.
  Assumes a 20 MHz core clock; included by bare name.
*/
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH

// ------------------------------------------------------------
// register offsets (7-bit serial address)
// ------------------------------------------------------------
`define A_FC2 7'h08
`define A_PIN0 7'h0B
`define A_PIN1 7'h0C
`define A_PIN2 7'h0D
`define A_IOP 7'h0E
`define A_WEXP 7'h14
`define A_WMH 7'h15
`define A_WML 7'h16
`define A_WCH 7'h17
`define A_WCL 7'h18

// ------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------
`define RST_BYTE 8'h00
`define FC2_MASK 8'hF6
`define IOP_MASK 8'h7F
`define WEXP_MASK 8'h3F

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FC2_LDC 2
`define EXP_LSB 2
`define TICK_SHIFT 5'h02

// ------------------------------------------------------------
// pin function codes
// ------------------------------------------------------------
`define FN_DEFAULT 5'h00
`define FN_WAKE 5'h01
`define FN_DIRECT 5'h02
`define FN_ANT1 5'h08
`define FN_ANT2 5'h09

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_NS 50
`define ANT_DWELL_NS 8000
`define ANT_DWELL_CYC ((`ANT_DWELL_NS + `CLK_NS - 1) / `CLK_NS)
`define LISTEN_UNITS 4

`endif

// ---- wake_pkg.sv ----
/*
  Types of the wake-up timer block: window state and the packed state record.
  Assumes nothing beyond a SystemVerilog elaborator.
*/
package wake_pkg;

  // ------------------------------------------------------------
  // receive window sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    LDC_IDLE = 2'b00,
    LDC_LISTEN = 2'b01,
    LDC_EXTEND = 2'b10
  } ldc_e;

  // ------------------------------------------------------------
  // all state of the block
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] sel_s;
    logic [1:0] sdi_s;
    logic [2:0] rc_s;
    logic [2:0] xt_s;
    logic [1:0] por_s;
    logic [1:0] mck_s;
    logic [3:0] bitcnt;
    logic [14:0] shift;
    logic [7:0] sdo_sh;
    logic sdo;
    logic sdo_oe;
    logic [7:0] fc2;
    logic [2:0][7:0] pin;
    logic [7:0] iop;
    logic [7:0] wexp;
    logic [15:0] wm;
    logic [17:0] pre;
    logic [15:0] count;
    logic irq_n;
    logic xtal_on;
    logic wake_flag;
    ldc_e ldc;
    logic [7:0] win;
    logic pre_seen;
    logic rx_win;
    logic rx_prev;
    logic ant_sel;
    logic locked;
    logic [7:0] dwell;
    logic [7:0] rssi_a;
    logic [7:0] rssi_b;
    logic [2:0] gout;
    logic [2:0] goe;
    logic [5:0] drv;
    logic [2:0] pull;
    logic ant1;
    logic ant2;
  } state_s;

endpackage

// ---- wake_timer.sv ----
/*
  Wake-up timer with receive duty cycling, three routed pins and antenna
  select, reached over the serial register port.
  Assumes: the 32 kHz RC clock, serial pins, reset-source and clock-out pins
  are asynchronous; mode, detector and status-read inputs share core_clk.
*/
// Behaviour
// - timer ticks from the internal 32.768 kHz RC clock by default
// - enabled timer in sleep counts the period; expiry pulls interrupt low if enabled
// - period is mantissa times 2^(exponent+2) ticks of 32.768 kHz
// - 2-bit fine field is held beside the 4-bit exponent
// - live 16-bit count readable anytime through two read-only bytes
// - expiry with interrupt enabled also starts the 30 MHz oscillator
// - expiry with interrupt disabled flags a pin only, no state change
// - external crystal select turns pin 0 into the oscillator pin
// - external crystal select moves the period and window timing onto the crystal ticks; the antenna dwell stays on core_clk cycles
// - duty-cycle mode opens receive each period, closes without preamble or sync
// - preamble plus sync extends receive by the programmed duration
// - duration is field times 2^(exponent+2) ticks, exponent shared
// - shutdown pulls every pin low
// - 5-bit function per pin; code zero gives reset, inverted reset, clock
// - 2-bit drive strength per pin, larger means stronger
// - diversity compares both antennas during preamble, keeps the stronger
// - diversity toggles the antennas until the packet starts
// - fixed antenna codes drive the tabled pairs in and out of receive
// - codes 1xx run diversity; 1xx codes idle at bit 0, 0xx codes idle at bit 1
`include "wake_regs.svh"

module wake_timer
  import wake_pkg::*;
#(
  parameter int DWELL_CYC = `ANT_DWELL_CYC,
  parameter int LISTEN_UNITS = `LISTEN_UNITS
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_sel_n, // serial select pin, low
  input wire logic spi_sdi, // serial data in
  output logic spi_sdo, // serial data out
  output logic spi_sdo_oe, // serial out enable
  input wire logic rc_osc_clk, // 32.768 kHz rc clock
  input wire logic timer_enable, // timer enable bit
  input wire logic ext_crystal_select, // external 32k crystal
  input wire logic timer_irq_enable, // timer interrupt enable
  input wire logic sleep_mode, // device is in sleep
  input wire logic shutdown, // device is in shutdown
  input wire logic status_read, // host read status, pulse
  input wire logic rx_on, // receiver commanded on
  input wire logic preamble_valid, // preamble found, pulse
  input wire logic preamble_invalid, // preamble timeout, pulse
  input wire logic sync_valid, // sync word found, pulse
  input wire logic [7:0] rssi, // signal strength
  input wire logic [7:0] rx_window_time, // window duration field
  input wire logic por, // power-on reset level
  input wire logic mcu_clk, // clock for the host
  input wire logic [2:0] gpio_in, // pad inputs
  output logic [2:0] gpio_out, // pad outputs
  output logic [2:0] gpio_oe, // pad enables
  output logic [5:0] pin_drive_strength, // 2 bits per pad
  output logic [2:0] pin_pullup_enable, // pad pull-ups
  output logic irq_out_n, // interrupt, low
  output logic xtal_start, // 30 MHz oscillator request
  output logic ldc_rx_on, // duty-cycle receive window
  output logic ant1, // antenna switch 1
  output logic ant2 // antenna switch 2
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (DWELL_CYC < 4 || DWELL_CYC > 255) begin : g_chk_dwell
    $error("dwell count out of range");
  end
  if (LISTEN_UNITS < 1 || LISTEN_UNITS > 255) begin : g_chk_listen
    $error("listen count out of range");
  end

  localparam logic [7:0] DWELL = 8'(DWELL_CYC);
  localparam logic [7:0] LISTEN = 8'(LISTEN_UNITS);

  state_s q;
  state_s d;
  logic tick;
  logic run;
  logic unit;
  logic expire;
  logic rx;
  logic [7:0] dwell_lim;
  logic [3:0] r_exp;
  logic [18:0] span;
  logic [17:0] lim;

  // register read mux; reserved bits read zero
  function automatic logic [7:0] rd_byte(input state_s s, input logic [6:0] a);
    case (a)
      `A_FC2: rd_byte = s.fc2;
      `A_PIN0: rd_byte = s.pin[0];
      `A_PIN1: rd_byte = s.pin[1];
      `A_PIN2: rd_byte = s.pin[2];
      `A_IOP: rd_byte = s.iop;
      `A_WEXP: rd_byte = s.wexp;
      `A_WMH: rd_byte = s.wm[15:8];
      `A_WML: rd_byte = s.wm[7:0];
      `A_WCH: rd_byte = s.count[15:8];
      `A_WCL: rd_byte = s.count[7:0];
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // ------------------------------------------------------------
  // timer decode
  // ------------------------------------------------------------
  // tick source follows the crystal select; edges only from settled stages
  assign tick = ext_crystal_select ? (q.xt_s[1] & ~q.xt_s[2])
                                   : (q.rc_s[1] & ~q.rc_s[2]);
  assign run = timer_enable & (sleep_mode | q.fc2[`FC2_LDC]);
  assign r_exp = q.wexp[`EXP_LSB +: 4];
  assign span = 19'h1 << (5'(r_exp) + `TICK_SHIFT);
  assign lim = 18'(span - 19'h1);
  assign unit = run & tick & (q.pre == lim);
  // a lowered mantissa still expires at the next unit rather than wrapping
  assign expire = unit & (q.wm != 16'h0) & (q.count >= q.wm - 16'h1);
  assign rx = rx_on | q.rx_win;
  assign dwell_lim = (q.fc2[7] & q.fc2[6]) ? (DWELL >> 1) : DWELL;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] wdat;
    logic [6:0] wadr;
    logic [2:0] code;
    logic o;
    wdat = {q.shift[6:0], q.sdi_s[1]};
    wadr = q.shift[13:7];
    code = q.fc2[7:5];
    o = 1'b0;
    d = q;
    // two-stage synchronisers, a third stage only for edge detection
    d.sclk_s = {q.sclk_s[1:0], spi_sclk};
    d.sel_s = {q.sel_s[0], spi_sel_n};
    d.sdi_s = {q.sdi_s[0], spi_sdi};
    d.rc_s = {q.rc_s[1:0], rc_osc_clk};
    d.xt_s = {q.xt_s[1:0], gpio_in[0]};
    d.por_s = {q.por_s[0], por};
    d.mck_s = {q.mck_s[0], mcu_clk};

    // serial port: rw bit, 7-bit address, 8 data bits, msb first
    if (q.sel_s[1]) begin
      d.bitcnt = 4'h0;
      d.sdo_oe = 1'b0;
      d.sdo = 1'b0;
    end else begin
      d.sdo_oe = 1'b1;
      if (q.sclk_s[1] & ~q.sclk_s[2]) begin
        d.shift = {q.shift[13:0], q.sdi_s[1]};
        d.bitcnt = q.bitcnt + 4'h1;
        if (q.bitcnt == 4'h7) begin
          d.sdo_sh = rd_byte(q, {q.shift[5:0], q.sdi_s[1]});
        end
        if (q.bitcnt == 4'hF && q.shift[14]) begin
          case (wadr)
            `A_FC2: d.fc2 = wdat & `FC2_MASK;
            `A_PIN0: d.pin[0] = wdat;
            `A_PIN1: d.pin[1] = wdat;
            `A_PIN2: d.pin[2] = wdat;
            `A_IOP: d.iop = wdat & `IOP_MASK;
            `A_WEXP: d.wexp = wdat & `WEXP_MASK;
            `A_WMH: d.wm[15:8] = wdat;
            `A_WML: d.wm[7:0] = wdat;
            default: ;
          endcase
        end
      end
      // data shifts out on falling edges of the second byte
      if ((~q.sclk_s[1] & q.sclk_s[2]) && q.bitcnt[3]) begin
        d.sdo = q.sdo_sh[7];
        d.sdo_sh = {q.sdo_sh[6:0], 1'b0};
      end
    end

    // period prescaler and counter, cleared while the timer is idle
    if (!run) begin
      d.pre = 18'h0;
      d.count = 16'h0;
    end else if (tick) begin
      d.pre = unit ? 18'h0 : q.pre + 18'h1;
      if (unit) begin
        d.count = expire ? 16'h0 : q.count + 16'h1;
      end
    end

    // interrupt and pin flag: a clear never loses a same-cycle expiry
    if (status_read) begin
      d.irq_n = 1'b1;
      d.wake_flag = 1'b0;
    end
    if (!sleep_mode) begin
      d.xtal_on = 1'b0;
    end
    if (expire) begin
      if (timer_irq_enable) begin
        d.irq_n = 1'b0;
        d.xtal_on = 1'b1;
      end else begin
        d.wake_flag = 1'b1;
      end
    end

    // duty-cycle receive window, counted in the same units as the period
    if (preamble_valid) begin
      d.pre_seen = 1'b1;
    end
    unique case (q.ldc)
      LDC_IDLE: begin
        if (expire & q.fc2[`FC2_LDC]) begin
          d.ldc = LDC_LISTEN;
          d.rx_win = 1'b1;
          d.win = 8'h0;
          d.pre_seen = 1'b0;
        end
      end
      LDC_LISTEN: begin
        if (unit) begin
          d.win = q.win + 8'h1;
        end
        if (sync_valid & (q.pre_seen | preamble_valid)) begin
          d.ldc = LDC_EXTEND;
          d.win = 8'h0;
        end else if (preamble_invalid | (unit & (q.win + 8'h1 >= LISTEN))) begin
          d.ldc = LDC_IDLE;
          d.rx_win = 1'b0;
        end
      end
      LDC_EXTEND: begin
        if (unit) begin
          d.win = q.win + 8'h1;
        end
        if ((unit & (q.win + 8'h1 >= rx_window_time)) | (rx_window_time == 8'h0)) begin
          d.ldc = LDC_IDLE;
          d.rx_win = 1'b0;
        end
      end
      default: begin
        d.ldc = LDC_IDLE;
        d.rx_win = 1'b0;
      end
    endcase
    if (!run) begin
      d.ldc = LDC_IDLE;
      d.rx_win = 1'b0;
    end

    // diversity: dwell on each antenna, keep its strength, lock at packet
    d.rx_prev = rx;
    if (rx & ~q.rx_prev) begin
      d.locked = 1'b0;
      d.ant_sel = 1'b0;
      d.dwell = 8'h0;
    end else if (rx & ~q.locked & code[2]) begin
      if (preamble_valid) begin
        d.locked = 1'b1;
        d.ant_sel = q.rssi_b > q.rssi_a;
      end else if (q.dwell == dwell_lim - 8'h1) begin
        d.dwell = 8'h0;
        d.ant_sel = ~q.ant_sel;
        if (q.ant_sel) begin
          d.rssi_b = rssi;
        end else begin
          d.rssi_a = rssi;
        end
      end else begin
        d.dwell = q.dwell + 8'h1;
      end
    end

    // antenna outputs
    if (!rx) begin
      d.ant1 = code[2] ? code[0] : code[1];
      d.ant2 = code[2] ? code[0] : code[1];
    end else if (code[2]) begin
      d.ant1 = d.ant_sel;
      d.ant2 = ~d.ant_sel;
    end else begin
      d.ant1 = code[0];
      d.ant2 = ~code[0];
    end

    // pad routing; shutdown overrides the crystal pin
    for (int i = 0; i < 3; i++) begin
      case (q.pin[i][4:0])
        `FN_DEFAULT: o = (i == 0) ? q.por_s[1] : (i == 1) ? ~q.por_s[1] : q.mck_s[1];
        `FN_WAKE: o = q.wake_flag;
        `FN_DIRECT: o = q.iop[i];
        `FN_ANT1: o = q.ant1;
        `FN_ANT2: o = q.ant2;
        default: o = 1'b0;
      endcase
      d.gout[i] = o;
      d.goe[i] = 1'b1;
      d.drv[2*i +: 2] = q.pin[i][7:6];
      d.pull[i] = q.pin[i][5] & ~shutdown;
      if (i == 0 && ext_crystal_select) begin
        d.gout[i] = 1'b0;
        d.goe[i] = 1'b0;
        d.pull[i] = 1'b0;
      end
      if (shutdown) begin
        d.gout[i] = 1'b0;
        d.goe[i] = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '0;
      q.irq_n <= 1'b1;
      q.sel_s <= 2'b11;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign spi_sdo = q.sdo;
  assign spi_sdo_oe = q.sdo_oe;
  assign gpio_out = q.gout;
  assign gpio_oe = q.goe;
  assign pin_drive_strength = q.drv;
  assign pin_pullup_enable = q.pull;
  assign irq_out_n = q.irq_n;
  assign xtal_start = q.xtal_on;
  assign ldc_rx_on = q.rx_win;
  assign ant1 = q.ant1;
  assign ant2 = q.ant2;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_irq_on_expire: assert property (expire && timer_irq_enable |=> !irq_out_n)
    else $error("interrupt not raised on expiry");
  a_irq_holds: assert property (!irq_out_n && !status_read |=> !irq_out_n)
    else $error("interrupt released without status read");
  a_irq_release: assert property (status_read && !expire |=> irq_out_n)
    else $error("interrupt not released after status read");
  a_xtal_wake: assert property (expire && timer_irq_enable && sleep_mode |=> xtal_start)
    else $error("oscillator not started on expiry");
  a_quiet_expiry: assert property (expire && !timer_irq_enable && !xtal_start && !status_read
                                   |=> !xtal_start && $stable(irq_out_n))
    else $error("state changed on masked expiry");
  // the next period must start from zero, or every later period runs short
  a_count_period: assert property (expire |=> q.count == 16'h0 && q.pre == 18'h0)
    else $error("period count not restarted after expiry");
  a_shutdown_pads: assert property (shutdown |=> gpio_out == 3'b000 && gpio_oe == 3'b111)
    else $error("pads not low in shutdown");
  a_crystal_pin: assert property (ext_crystal_select && !shutdown |=> !gpio_oe[0])
    else $error("pin 0 driven in crystal mode");
  a_window_open: assert property (expire && q.fc2[`FC2_LDC] && q.ldc == LDC_IDLE
                                  |=> ldc_rx_on)
    else $error("receive window not opened");
  a_fixed_ant: assert property (q.fc2[7:5] == 3'b011 && $stable(q.fc2) && !rx
                                |=> ant1 && ant2)
    else $error("idle antenna pair wrong");
  a_div_toggle: assert property (q.fc2[7] && rx && q.rx_prev && !q.locked && !preamble_valid
                                 && q.dwell == dwell_lim - 8'h1
                                 |=> q.ant_sel != $past(q.ant_sel))
    else $error("antenna did not toggle");

  c_irq_expiry: cover property (expire && timer_irq_enable ##[1:20] status_read);
  c_window_extend: cover property (q.ldc == LDC_LISTEN ##1 q.ldc == LDC_EXTEND);
  c_ant_locked: cover property (q.fc2[7] && rx && !q.locked ##1 q.locked);

endmodule

// ---- host_model.sv ----
/*
  Host side: serial register master and interrupt service.
  Assumes core_clk times everything; the bench calls its tasks.
*/
module host_model (
  input wire logic core_clk, // core clock
  input wire logic spi_sdo, // serial data from device
  input wire logic irq_out_n, // interrupt, low
  output logic spi_sclk, // serial clock
  output logic spi_sel_n, // serial select, low
  output logic spi_sdi, // serial data to device
  output logic status_read // status read pulse
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: deselected, clock low
  initial begin
    spi_sclk = 1'b0;
    spi_sel_n = 1'b1;
    spi_sdi = 1'b0;
    status_read = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one 16-bit frame, msb first; 5 cycles per half keeps the 4-cycle minimum
  task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic [15:0] word;
    word = {wr, a, wd};
    rd = 8'h00;
    @(posedge core_clk);
    spi_sel_n <= 1'b0;
    cyc(4);
    for (int i = 15; i >= 0; i--) begin
      spi_sdi <= word[i];
      cyc(5);
      spi_sclk <= 1'b1;
      if (i < 8) rd[i] = spi_sdo; // taken at the rising edge
      cyc(5);
      spi_sclk <= 1'b0;
    end
    cyc(5);
    spi_sel_n <= 1'b1;
    spi_sdi <= ~spi_sdi; // a released line must not look like held data
    cyc(6);
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    frame(1'b1, a, d, unused);
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    frame(1'b0, a, 8'h00, d);
  endtask

  // service after an interrupt: the status registers are read
  task automatic ack_irq();
    @(posedge core_clk);
    status_read <= 1'b1;
    @(posedge core_clk);
    status_read <= 1'b0;
  endtask
endmodule

// ---- tb.sv ----
/*
  Self-checking bench for the wake-up timer block.
  Assumes wake_regs.svh, wake_pkg and host_model are compiled first.
*/
`include "wake_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DWELL = 8;
  logic core_clk = 1'b0, sys_rst = 1'b1, rc_osc_clk = 1'b0, timer_enable = 1'b0;
  logic ext_crystal_select = 1'b0, timer_irq_enable = 1'b0, sleep_mode = 1'b0;
  logic shutdown = 1'b0, rx_on = 1'b0, preamble_valid = 1'b0, preamble_invalid = 1'b0;
  logic sync_valid = 1'b0, por = 1'b0, mcu_clk = 1'b0;
  logic [7:0] rssi = 8'h00, rx_window_time = 8'h00;
  logic [2:0] gpio_in = 3'h0;
  logic spi_sclk, spi_sel_n, spi_sdi, status_read, spi_sdo, spi_sdo_oe;
  logic irq_out_n, xtal_start, ldc_rx_on, ant1, ant2, seen;
  logic oe_seen = 1'b0;
  logic [2:0] gpio_out, gpio_oe, pin_pullup_enable;
  logic [5:0] pin_drive_strength;
  logic [7:0] d;
  int error_cnt = 0, checks = 0;
  logic [6:0] ra [10] = '{`A_FC2, `A_PIN0, `A_PIN1, `A_PIN2, `A_IOP, `A_WEXP, `A_WMH,
                          `A_WML, `A_WCH, 7'h30};
  logic [7:0] wv [10] = '{8'hFF, 8'h5A, 8'h81, 8'hC3, 8'hFF, 8'hFF, 8'hA5, 8'h3C,
                          8'hFF, 8'hFF};
  logic [7:0] ev [10] = '{8'hF6, 8'h5A, 8'h81, 8'hC3, 8'h7F, 8'h3F, 8'hA5, 8'h3C,
                          8'h00, 8'h00};

  always #25 core_clk = ~core_clk;
  // received strength follows the selected antenna: the ant1 side is stronger
  always @(posedge core_clk) rssi <= ant1 ? 8'h80 : 8'h10;
  // the serial output enable must have been seen during some frame
  always @(posedge core_clk) if (spi_sdo_oe === 1'b1) oe_seen <= 1'b1;

  host_model host (.core_clk, .spi_sdo, .irq_out_n, .spi_sclk, .spi_sel_n, .spi_sdi,
                   .status_read);
  wake_timer #(.DWELL_CYC(DWELL), .LISTEN_UNITS(4)) dut (.core_clk, .sys_rst, .spi_sclk,
    .spi_sel_n, .spi_sdi, .spi_sdo, .spi_sdo_oe, .rc_osc_clk, .timer_enable,
    .ext_crystal_select, .timer_irq_enable, .sleep_mode, .shutdown, .status_read, .rx_on,
    .preamble_valid, .preamble_invalid, .sync_valid, .rssi, .rx_window_time, .por,
    .mcu_clk, .gpio_in, .gpio_out, .gpio_oe, .pin_drive_strength, .pin_pullup_enable,
    .irq_out_n, .xtal_start, .ldc_rx_on, .ant1, .ant2);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    host.read_reg(a, d);
    expect_eq(d, exp);
  endtask

  // slow clock ticks, from the rc source or from the crystal pad
  task automatic tick(input int n, input logic on_pad);
    repeat (n) begin
      @(posedge core_clk);
      if (on_pad) gpio_in[0] <= 1'b1;
      else rc_osc_clk <= 1'b1;
      cyc(4);
      gpio_in[0] <= 1'b0;
      rc_osc_clk <= 1'b0;
      cyc(4);
    end
  endtask

  task automatic set_timer(input logic [3:0] r, input logic [15:0] m);
    host.write_reg(`A_WEXP, {2'b00, r, 2'b00});
    host.write_reg(`A_WMH, m[15:8]);
    host.write_reg(`A_WML, m[7:0]);
  endtask

  // watchdog: the sequence needs about 14000 cycles
  initial begin
    cyc(80000);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(12);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    expect_eq(irq_out_n, 1'b1);
    cyc(4);
    expect_eq(gpio_oe, 3'h7);
    for (int i = 0; i < 10; i++) rd_chk(ra[i], `RST_BYTE);
    for (int i = 0; i < 10; i++) host.write_reg(ra[i], wv[i]);
    for (int i = 0; i < 10; i++) rd_chk(ra[i], ev[i]);
    for (int i = 0; i < 8; i++) host.write_reg(ra[i], 8'h00);
    expect_eq({oe_seen, spi_sdo_oe}, 2'b10);
    $display("test registers done");

    // expiry after M units of 2^(R+2) ticks; both settings give 8 ticks
    timer_irq_enable <= 1'b1;
    sleep_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      set_timer(4'(k), 16'(2 - k));
      timer_enable <= 1'b1;
      tick(4, 1'b0);
      rd_chk(`A_WCL, (k == 0) ? 8'h01 : 8'h00);
      rd_chk(`A_WCH, 8'h00);
      tick(3, 1'b0);
      cyc(6);
      expect_eq(irq_out_n, 1'b1);
      tick(1, 1'b0);
      cyc(6);
      expect_eq({irq_out_n, xtal_start}, 2'b01);
      cyc(30);
      expect_eq(irq_out_n, 1'b0);
      host.ack_irq();
      cyc(3);
      expect_eq(irq_out_n, 1'b1);
      timer_enable <= 1'b0;
    end
    sleep_mode <= 1'b0;
    cyc(3);
    expect_eq(xtal_start, 1'b0);
    $display("test timer done");

    // expiry flagged on pad 1 only, with the interrupt off
    timer_irq_enable <= 1'b0;
    sleep_mode <= 1'b1;
    host.write_reg(`A_PIN1, {3'b000, `FN_WAKE});
    set_timer(4'h0, 16'h0001);
    timer_enable <= 1'b1;
    tick(4, 1'b0);
    cyc(6);
    expect_eq({irq_out_n, xtal_start, gpio_out[1]}, 3'b101);
    host.ack_irq();
    timer_enable <= 1'b0;
    $display("test pin flag done");

    // crystal on pad 0 replaces the rc ticks
    host.write_reg(`A_PIN0, 8'hE0);
    host.write_reg(`A_PIN2, 8'h40);
    expect_eq(pin_drive_strength, 6'h13);
    expect_eq(pin_pullup_enable[0], 1'b1);
    ext_crystal_select <= 1'b1;
    timer_irq_enable <= 1'b1;
    cyc(4);
    expect_eq(pin_pullup_enable[0], 1'b0);
    timer_enable <= 1'b1;
    tick(8, 1'b0);
    cyc(6);
    expect_eq(irq_out_n, 1'b1);
    tick(4, 1'b1);
    cyc(6);
    expect_eq(irq_out_n, 1'b0);
    host.ack_irq();
    timer_enable <= 1'b0;
    ext_crystal_select <= 1'b0;
    sleep_mode <= 1'b0;
    $display("test crystal done");

    // default pad functions, then shutdown
    host.write_reg(`A_PIN1, 8'h00);
    por <= 1'b1;
    mcu_clk <= 1'b1;
    cyc(6);
    expect_eq({gpio_oe, gpio_out}, 6'h3D);
    por <= 1'b0;
    mcu_clk <= 1'b0;
    cyc(6);
    expect_eq(gpio_out, 3'b010);
    shutdown <= 1'b1;
    cyc(4);
    expect_eq({gpio_out, pin_pullup_enable}, 6'h00);
    shutdown <= 1'b0;
    $display("test pads done");

    // antenna levels on pads 0 and 1, a direct port bit on pad 2
    host.write_reg(`A_IOP, 8'h04);
    host.write_reg(`A_PIN0, {3'b000, `FN_ANT1});
    host.write_reg(`A_PIN1, {3'b000, `FN_ANT2});
    host.write_reg(`A_PIN2, {3'b000, `FN_DIRECT});

    // every antenna code outside receive, fixed codes in receive
    for (int c = 0; c < 8; c++) begin
      host.write_reg(`A_FC2, {3'(c), 5'h00});
      cyc(3);
      expect_eq({ant1, ant2, gpio_out}, ((c < 4) ? c[1] : c[0]) ? 5'h1F : 5'h04);
      if (c < 4) begin
        rx_on <= 1'b1;
        cyc(3);
        expect_eq({ant1, ant2, gpio_out}, c[0] ? 5'h15 : 5'h0E);
        rx_on <= 1'b0;
      end
    end
    // diversity and beacon variant: toggle, then lock to the stronger side
    for (int c = 4; c < 8; c += 2) begin
      host.write_reg(`A_FC2, {3'(c), 5'h00});
      rx_on <= 1'b1;
      cyc(2);
      expect_eq({ant1, ant2}, 2'b01);
      seen = 1'b0;
      repeat (2 * DWELL) begin
        @(posedge core_clk);
        if (ant1 === 1'b1) seen = 1'b1;
      end
      expect_eq(seen, 1'b1);
      cyc(3 * DWELL); // preamble long enough for several dwells
      preamble_valid <= 1'b1;
      @(posedge core_clk);
      preamble_valid <= 1'b0;
      cyc(2 * DWELL);
      expect_eq({ant1, ant2}, 2'b10);
      cyc(DWELL + 3);
      expect_eq({ant1, ant2}, 2'b10);
      rx_on <= 1'b0;
    end
    $display("test antenna done");

    // duty cycle: window per period, closed on a bad preamble, extended on sync
    host.write_reg(`A_FC2, 8'h04);
    set_timer(4'h0, 16'h0003);
    rx_window_time <= 8'h02;
    timer_enable <= 1'b1;
    tick(12, 1'b0);
    cyc(4);
    expect_eq(ldc_rx_on, 1'b1);
    preamble_invalid <= 1'b1;
    @(posedge core_clk);
    preamble_invalid <= 1'b0;
    cyc(3);
    expect_eq(ldc_rx_on, 1'b0);
    tick(12, 1'b0);
    cyc(4);
    expect_eq(ldc_rx_on, 1'b1);
    preamble_valid <= 1'b1;
    @(posedge core_clk);
    preamble_valid <= 1'b0;
    sync_valid <= 1'b1;
    @(posedge core_clk);
    sync_valid <= 1'b0;
    tick(4, 1'b0);
    expect_eq(ldc_rx_on, 1'b1);
    tick(6, 1'b0);
    expect_eq(ldc_rx_on, 1'b0);
    timer_enable <= 1'b0;
    $display("test duty cycle done");
    tally_and_finish();
  end
endmodule
